// ==== verilog/etsr_pkg.sv ====
`default_nettype none
package etsr_pkg;
  // register byte offsets
  localparam logic [11:0] ETSR_SAMPLE5_PHASE_OFS       = 12'h58C;
  localparam logic [11:0] ETSR_SAMPLE6_NANOSECONDS_OFS = 12'h590;
  localparam logic [11:0] ETSR_SAMPLE6_SECONDS_OFS     = 12'h594;
  localparam logic [11:0] ETSR_SAMPLE6_PHASE_OFS       = 12'h598;
  localparam logic [11:0] ETSR_SAMPLE7_NANOSECONDS_OFS = 12'h59C;
  localparam logic [11:0] ETSR_SAMPLE7_SECONDS_OFS     = 12'h5A0;
  localparam logic [11:0] ETSR_UNIT_INDEX_OFS          = 12'h5FC;
  // field layout
  localparam int ETSR_ADDR_W      = 12;
  localparam int ETSR_NS_W        = 30;
  localparam int ETSR_SLOT_W      = 3;
  localparam int ETSR_EDGE_BIT    = 30;
  localparam int ETSR_UNIT_BIT    = 8;
  localparam int ETSR_UNITS       = 2;
  localparam logic [31:0] ETSR_ZERO_WORD = 32'h0000_0000;
  // slot codes within the 40 ns reference period
  localparam logic [2:0] ETSR_SLOT_0NS  = 3'h0;
  localparam logic [2:0] ETSR_SLOT_8NS  = 3'h1;
  localparam logic [2:0] ETSR_SLOT_16NS = 3'h2;
  localparam logic [2:0] ETSR_SLOT_24NS = 3'h3;
  localparam logic [2:0] ETSR_SLOT_32NS = 3'h4;
  // axi responses
  localparam logic [1:0] ETSR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ETSR_RESP_SLVERR = 2'h2;
endpackage : etsr_pkg
`default_nettype wire

// ==== verilog/etsr_sample_regs.sv ====
// Contract
// - phase word low bits give 8 ns slot
// - 16 ns slot code unresolved, use 010
// - nanoseconds bit 30 marks rising edge
// - nanoseconds in 29:0, bit 31 zero
// - seconds fill 32 bits, reset zero
// - unit index bit 8 selects sample source
// - three words: ns, seconds, phase; here sample 5 has only its phase word and sample 7 has no phase word
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module etsr_sample_regs (
  // clock and reset
  input  wire  logic                              clock,
  input  wire  logic                              resetn,
  // capture side, one strobe per sample, shared by both units; cap_unit picks the unit
  input  wire  logic                              cap5_valid,
  input  wire  logic                              cap6_valid,
  input  wire  logic                              cap7_valid,
  input  wire  logic                              cap_unit,
  input  wire  logic [etsr_pkg::ETSR_NS_W-1:0]    cap_nanoseconds,
  input  wire  logic [31:0]                       cap_seconds,
  input  wire  logic [etsr_pkg::ETSR_SLOT_W-1:0]  cap_slot,
  input  wire  logic                              cap_rising,
  // axi4-lite write address
  input  wire  logic [etsr_pkg::ETSR_ADDR_W-1:0]  s_axi_awaddr,
  input  wire  logic                              s_axi_awvalid,
  output var   logic                              s_axi_awready,
  // axi4-lite write data
  input  wire  logic [31:0]                       s_axi_wdata,
  input  wire  logic [3:0]                        s_axi_wstrb,
  input  wire  logic                              s_axi_wvalid,
  output var   logic                              s_axi_wready,
  // axi4-lite write response
  output var   logic [1:0]                        s_axi_bresp,
  output var   logic                              s_axi_bvalid,
  input  wire  logic                              s_axi_bready,
  // axi4-lite read address
  input  wire  logic [etsr_pkg::ETSR_ADDR_W-1:0]  s_axi_araddr,
  input  wire  logic                              s_axi_arvalid,
  output var   logic                              s_axi_arready,
  // axi4-lite read data
  output var   logic [31:0]                       s_axi_rdata,
  output var   logic [1:0]                        s_axi_rresp,
  output var   logic                              s_axi_rvalid,
  input  wire  logic                              s_axi_rready
);
  import etsr_pkg::*;

  // one sample record per unit; fields kept side by side so they move as one
  // sample 5 keeps only its phase here, its time words sit outside this block
  logic [ETSR_SLOT_W-1:0] s5_slot_q [ETSR_UNITS];
  logic [ETSR_SLOT_W-1:0] s5_slot_d [ETSR_UNITS];
  logic [ETSR_NS_W-1:0]   s6_ns_q   [ETSR_UNITS];
  logic [ETSR_NS_W-1:0]   s6_ns_d   [ETSR_UNITS];
  logic [31:0]            s6_sec_q  [ETSR_UNITS];
  logic [31:0]            s6_sec_d  [ETSR_UNITS];
  logic [ETSR_SLOT_W-1:0] s6_slot_q [ETSR_UNITS];
  logic [ETSR_SLOT_W-1:0] s6_slot_d [ETSR_UNITS];
  logic                   s6_edge_q [ETSR_UNITS];
  logic                   s6_edge_d [ETSR_UNITS];
  logic [ETSR_NS_W-1:0]   s7_ns_q   [ETSR_UNITS];
  logic [ETSR_NS_W-1:0]   s7_ns_d   [ETSR_UNITS];
  logic [31:0]            s7_sec_q  [ETSR_UNITS];
  logic [31:0]            s7_sec_d  [ETSR_UNITS];
  logic                   s7_edge_q [ETSR_UNITS];
  logic                   s7_edge_d [ETSR_UNITS];
  logic                   unit_sel_q;
  logic                   unit_sel_d;

  // maps the raw slot code; 16 ns comes out as 010 (reserved 101 never shown)
  function automatic logic [ETSR_SLOT_W-1:0] etsr_slot_fix(input logic [ETSR_SLOT_W-1:0] c);
    unique case (c)
      ETSR_SLOT_0NS, ETSR_SLOT_8NS, ETSR_SLOT_16NS,
      ETSR_SLOT_24NS, ETSR_SLOT_32NS: etsr_slot_fix = c;
      default:                        etsr_slot_fix = ETSR_SLOT_0NS;
    endcase
  endfunction : etsr_slot_fix

  // capture: every field of a slot loads on the same strobe, so a read
  // never mixes parts of two events
  always_comb begin
    s5_slot_d = s5_slot_q;
    s6_ns_d   = s6_ns_q;
    s6_sec_d  = s6_sec_q;
    s6_slot_d = s6_slot_q;
    s6_edge_d = s6_edge_q;
    s7_ns_d   = s7_ns_q;
    s7_sec_d  = s7_sec_q;
    s7_edge_d = s7_edge_q;
    if (cap5_valid) begin
      s5_slot_d[cap_unit] = etsr_slot_fix(cap_slot);
    end
    if (cap6_valid) begin
      s6_ns_d[cap_unit]   = cap_nanoseconds;
      s6_sec_d[cap_unit]  = cap_seconds;
      s6_slot_d[cap_unit] = etsr_slot_fix(cap_slot);
      s6_edge_d[cap_unit] = cap_rising;
    end
    if (cap7_valid) begin
      s7_ns_d[cap_unit]   = cap_nanoseconds;
      s7_sec_d[cap_unit]  = cap_seconds;
      s7_edge_d[cap_unit] = cap_rising;
    end
  end

  // capture store registers; every field clears on reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int u = 0; u < ETSR_UNITS; u++) begin
        s5_slot_q[u] <= '0;
        s6_ns_q[u]   <= '0;
        s6_sec_q[u]  <= '0;
        s6_slot_q[u] <= '0;
        s6_edge_q[u] <= 1'b0;
        s7_ns_q[u]   <= '0;
        s7_sec_q[u]  <= '0;
        s7_edge_q[u] <= 1'b0;
      end
    end else begin
      s5_slot_q <= s5_slot_d;
      s6_ns_q   <= s6_ns_d;
      s6_sec_q  <= s6_sec_d;
      s6_slot_q <= s6_slot_d;
      s6_edge_q <= s6_edge_d;
      s7_ns_q   <= s7_ns_d;
      s7_sec_q  <= s7_sec_d;
      s7_edge_q <= s7_edge_d;
    end
  end

  // nanoseconds word layout: reserved top bit, edge flag, value
  function automatic logic [31:0] etsr_ns_word(input logic e, input logic [ETSR_NS_W-1:0] n);
    etsr_ns_word                = ETSR_ZERO_WORD;
    etsr_ns_word[ETSR_NS_W-1:0] = n;
    etsr_ns_word[ETSR_EDGE_BIT] = e;
  endfunction : etsr_ns_word

  // bus addresses compare on the word; the two byte bits are ignored
  function automatic logic [ETSR_ADDR_W-1:0] etsr_word_addr(input logic [ETSR_ADDR_W-1:0] a);
    etsr_word_addr = {a[ETSR_ADDR_W-1:2], 2'h0};
  endfunction : etsr_word_addr

  // phase word layout: reserved zeros above the slot code
  function automatic logic [31:0] etsr_phase_word(input logic [ETSR_SLOT_W-1:0] c);
    etsr_phase_word                  = ETSR_ZERO_WORD;
    etsr_phase_word[ETSR_SLOT_W-1:0] = c;
  endfunction : etsr_phase_word

  // unit index word: only the select bit exists, the rest reads zero
  function automatic logic [31:0] etsr_unit_word(input logic s);
    etsr_unit_word                = ETSR_ZERO_WORD;
    etsr_unit_word[ETSR_UNIT_BIT] = s;
  endfunction : etsr_unit_word

  // write channel state
  logic       aw_seen_q, aw_seen_d;
  logic       w_seen_q,  w_seen_d;
  logic [ETSR_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;

  // write path: address and data taken in either order, reply after both
  always_comb begin
    aw_seen_d  = aw_seen_q;
    w_seen_d   = w_seen_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    unit_sel_d = unit_sel_q;
    if (s_axi_awvalid && !aw_seen_q && !bvalid_q) begin
      aw_seen_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_seen_q && !bvalid_q) begin
      w_seen_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (aw_seen_q && w_seen_q) begin
      aw_seen_d = 1'b0;
      w_seen_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = ETSR_RESP_SLVERR; // sample words are read only
      if (etsr_word_addr(awaddr_q) == ETSR_UNIT_INDEX_OFS) begin
        bresp_d = ETSR_RESP_OKAY;
        if (wstrb_q[1]) begin
          unit_sel_d = wdata_q[ETSR_UNIT_BIT];
        end
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // write path registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_seen_q  <= 1'b0;
      w_seen_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= ETSR_ZERO_WORD;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= ETSR_RESP_OKAY;
      unit_sel_q <= 1'b0;
    end else begin
      aw_seen_q  <= aw_seen_d;
      w_seen_q   <= w_seen_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      unit_sel_q <= unit_sel_d;
    end
  end

  // ready is a registered pulse in the cycle after the acceptance; it is
  // held off while a pulse stands so a held valid is never taken twice
  logic awready_q, awready_d;
  logic wready_q,  wready_d;
  always_comb begin
    awready_d = s_axi_awvalid && !aw_seen_q && !bvalid_q && !awready_q;
    wready_d  = s_axi_wvalid && !w_seen_q && !bvalid_q && !wready_q;
  end

  // ready pulse registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
    end
  end

  // read state
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        arready_q, arready_d;

  // read decode; the selected unit chooses which record answers
  always_comb begin
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    arready_d = 1'b0;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q && !arready_q) begin
      arready_d = 1'b1;
      rvalid_d  = 1'b1;
      rresp_d   = ETSR_RESP_OKAY;
      unique case (etsr_word_addr(s_axi_araddr))
        ETSR_SAMPLE5_PHASE_OFS:
          rdata_d = etsr_phase_word(s5_slot_q[unit_sel_q]);
        ETSR_SAMPLE6_NANOSECONDS_OFS:
          rdata_d = etsr_ns_word(s6_edge_q[unit_sel_q], s6_ns_q[unit_sel_q]);
        ETSR_SAMPLE6_SECONDS_OFS:
          rdata_d = s6_sec_q[unit_sel_q];
        ETSR_SAMPLE6_PHASE_OFS:
          rdata_d = etsr_phase_word(s6_slot_q[unit_sel_q]);
        ETSR_SAMPLE7_NANOSECONDS_OFS:
          rdata_d = etsr_ns_word(s7_edge_q[unit_sel_q], s7_ns_q[unit_sel_q]);
        ETSR_SAMPLE7_SECONDS_OFS:
          rdata_d = s7_sec_q[unit_sel_q];
        ETSR_UNIT_INDEX_OFS:
          rdata_d = etsr_unit_word(unit_sel_q);
        default: begin
          rdata_d = ETSR_ZERO_WORD;
          rresp_d = ETSR_RESP_SLVERR;
        end
      endcase
    end
  end

  // read registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rvalid_q  <= 1'b0;
      rdata_q   <= ETSR_ZERO_WORD;
      rresp_q   <= ETSR_RESP_OKAY;
      arready_q <= 1'b0;
    end else begin
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      arready_q <= arready_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule : etsr_sample_regs
`default_nettype wire

// ==== tb/etsr_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module etsr_checker
  import etsr_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // read side
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // a read is taken only when nothing is outstanding
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  endsequence
  chk_rd_answer: assert property (s_rd_take |=> s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  chk_ns_top: assert property (s_axi_rvalid && s_axi_arready
    && s_axi_araddr inside {12'h590, 12'h59C} |-> !s_axi_rdata[31])
    else $error("nanoseconds top bit set");
  chk_phase_code: assert property (s_axi_rvalid && s_axi_arready
    && s_axi_araddr inside {12'h58C, 12'h598}
    |-> s_axi_rdata[31:3] == 29'h0 && s_axi_rdata[2:0] <= 3'h4)
    else $error("phase word out of range");
  chk_unmapped_err: assert property (s_axi_rvalid && s_axi_arready
    && s_axi_araddr[11:2] > 10'h168 && s_axi_araddr[11:2] != 10'h17F
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (s_axi_rvalid && s_axi_arready
    && s_axi_araddr[1:0] == 2'h0 && s_axi_araddr inside {[12'h58C:12'h5A0]}
    |-> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  chk_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response late");
endmodule : etsr_checker
bind etsr_sample_regs etsr_checker i_chk (.clock, .resetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import etsr_pkg::*;
  logic clock, resetn, cap5_valid, cap6_valid, cap7_valid, cap_unit, cap_rising, u;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [29:0] cap_nanoseconds;
  logic [31:0] cap_seconds, s_axi_wdata, s_axi_rdata;
  logic [2:0]  cap_slot;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_rd[$];
  logic [1:0]  exp_wr[$];
  // model: ns6, s6, ns7, s7 per unit; phase 5 and 6
  logic [31:0] ev [2][4] = '{default: 32'h0};
  logic [31:0] ph [2][2] = '{default: 32'h0};
  logic [11:0] ad [7] = '{12'h590, 12'h594, 12'h59C, 12'h5A0, 12'h58C, 12'h598, 12'h5FC};
  int tests_run, bad_count, cycles;
  etsr_sample_regs i_dut (.clock, .resetn, .cap5_valid, .cap6_valid, .cap7_valid, .cap_unit,
    .cap_nanoseconds, .cap_seconds, .cap_slot, .cap_rising, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic end_sim();
    check("pending results", 34'h0, 34'(exp_rd.size() + exp_wr.size()));
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic check(input string n, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (e !== g) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check
  function automatic logic [31:0] ex(input logic [11:0] a);
    for (int i = 0; i < 4; i++) if (a == ad[i]) return ev[u][i];
    if (a == ETSR_UNIT_INDEX_OFS) return {23'h0, u, 8'h0};
    return (a == ETSR_SAMPLE5_PHASE_OFS) ? ph[u][0] : ph[u][1];
  endfunction : ex
  // one capture strobe; all fields of a sample land on the same edge
  task automatic cap(input int k, input logic un, input logic [2:0] sl);
    logic [31:0] n, s;
    n = $urandom;
    s = $urandom;
    @(posedge clock);
    {cap5_valid, cap6_valid, cap7_valid} <= {k == 5, k == 6, k == 7};
    cap_unit <= un;
    cap_nanoseconds <= n[29:0];
    cap_seconds <= s;
    cap_slot <= sl;
    cap_rising <= n[31];
    if (k < 7) ph[un][k - 5] = {29'h0, (sl > 3'h4) ? 3'h0 : sl};
    if (k > 5) ev[un][2 * (k - 6)] = {1'b0, n[31], n[29:0]};
    if (k > 5) ev[un][2 * (k - 6) + 1] = s;
    @(posedge clock);
    {cap5_valid, cap6_valid, cap7_valid} <= 3'h0;
  endtask : cap
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_rd.push_back({r, d});
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_wr.push_back(r);
    if (a == ETSR_UNIT_INDEX_OFS) u = d[8];
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask : wr
  // results are taken in order as the slave hands them over
  always @(posedge clock) begin
    if (resetn && s_axi_rvalid === 1'b1 && s_axi_rready)
      check("read word", exp_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (resetn && s_axi_bvalid === 1'b1 && s_axi_bready)
      check("write resp", {32'h0, exp_wr.pop_front()}, {32'h0, s_axi_bresp});
  end
  // cut a hang short; the whole sequence needs well under this
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(28));
    {resetn, cap5_valid, cap6_valid, cap7_valid, cap_unit, cap_rising, u} = 7'h0;
    {cap_nanoseconds, cap_seconds, cap_slot, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    foreach (ad[i]) rd(ad[i], ex(ad[i]), ETSR_RESP_OKAY);
    rd(12'h5A4, 32'h0, ETSR_RESP_SLVERR);
    wr(ETSR_SAMPLE6_NANOSECONDS_OFS, 32'hFFFF_FFFF, ETSR_RESP_SLVERR);
    rd(ETSR_SAMPLE6_NANOSECONDS_OFS, 32'h0, ETSR_RESP_OKAY);
    cap(6, 1'b1, 3'h1);
    cap(7, 1'b1, 3'h0);
    cap(6, 1'b0, 3'h3);
    // each unit shows only its own samples
    for (int un = 1; un >= 0; un--) begin
      wr(ETSR_UNIT_INDEX_OFS, {23'h0, un[0], 8'h0}, ETSR_RESP_OKAY);
      rd(ETSR_UNIT_INDEX_OFS, ex(ETSR_UNIT_INDEX_OFS), ETSR_RESP_OKAY);
      for (int i = 0; i < 4; i++) rd(ad[i], ex(ad[i]), ETSR_RESP_OKAY);
    end
    // every slot code, reserved ones included, read back right after capture
    for (int k = 0; k < 8; k++) begin
      cap(6, 1'b0, k[2:0]);
      cap(5, 1'b0, 3'(7 - k));
      for (int i = 0; i < 6; i++) rd(ad[i], ex(ad[i]), ETSR_RESP_OKAY);
    end
    // select unit 1, then a reset in mid-run must clear samples and select
    wr(ETSR_UNIT_INDEX_OFS, 32'h0000_0100, ETSR_RESP_OKAY);
    resetn <= 1'b0;
    ev = '{default: 32'h0};
    ph = '{default: 32'h0};
    u = 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    foreach (ad[i]) rd(ad[i], ex(ad[i]), ETSR_RESP_OKAY);
    repeat (4) @(posedge clock);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
